// >>> rtl/tsb_defs.svh
`ifndef TSB_DEFS_SVH
`define TSB_DEFS_SVH
`define TSB_SLOTS 4'h9
`define TSB_LAST_SLOT 4'h8
`define TSB_PROX_SLOT 4'h8
`define TSB_CLK_HZ 20000000
`define TSB_PWM_HZ 2000000
`define TSB_PWM_DIV (`TSB_CLK_HZ / `TSB_PWM_HZ)
`define TSB_PHASE_MS_MIN 5
`define TSB_PHASE_MS_MAX 30
`define TSB_CYC_PER_MS (`TSB_CLK_HZ / 1000)
`define TSB_TONE_BASE_HZ 1000
`define TSB_HALF_1K (`TSB_CLK_HZ / (2 * `TSB_TONE_BASE_HZ))
`define TSB_DUTY_W 6
`define TSB_ACTIVE_MS 40
`define TSB_SLEEP_MS 200
`endif

// >>> rtl/tsb_pkg.sv
package tsb_pkg;
    typedef enum logic [1:0] {
        TSB_REP_ALL = 2'h0,
        TSB_REP_SINGLE = 2'h1,
        TSB_REP_STRONG = 2'h2
    } tsb_rep_t;
    typedef enum logic [1:0] {
        TSB_BZ_IDLE = 2'h0,
        TSB_BZ_PH1 = 2'h1,
        TSB_BZ_PH2 = 2'h2
    } tsb_bz_t;
endpackage

// >>> rtl/tsb_pwm.sv
`timescale 1ns/1ps
`include "tsb_defs.svh"
module tsb_pwm #(
    parameter int DIV = `TSB_PWM_DIV
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [`TSB_DUTY_W-1:0] duty,
    output logic pwmOut
);
    logic [7:0] divReg;
    logic [`TSB_DUTY_W-1:0] phaseReg;
    logic [`TSB_DUTY_W-1:0] dutyReg;
    wire divWrap = (divReg == 8'(DIV - 1));
    // duty latched at period start so a change never makes a runt pulse
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            divReg <= 8'h00;
            phaseReg <= 6'h00;
            dutyReg <= 6'h00;
            pwmOut <= 1'b0;
        end
        else
        begin
            divReg <= divWrap ? 8'h00 : divReg + 8'h01;
            if (divWrap)
            begin
                phaseReg <= phaseReg + 6'h01;
                if (phaseReg == 6'h3F)
                    dutyReg <= duty;
                pwmOut <= ((phaseReg == 6'h3F) ? duty : dutyReg) > (phaseReg + 6'h01);
            end
        end
    end
endmodule

// >>> rtl/tsb_touch_scan.sv
`timescale 1ns/1ps
`include "tsb_defs.svh"
module tsb_touch_scan #(
    parameter int NCH = 8,
    parameter int DW = 12,
    parameter int SLOT_CYC = 2000,
    parameter int SKIP_W = 4
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [NCH-1:0] chanEnable,
    input wire logic proxEnable,
    input wire logic [NCH-1:0] proxCombineMask,
    input wire logic [DW-1:0] senseValue,
    input wire logic senseDone,
    input wire logic [DW-1:0] threshold,
    input wire logic [DW-1:0] hysteresis,
    input wire logic [SKIP_W-1:0] activeSkip,
    input wire logic [SKIP_W-1:0] sleepSkip,
    input wire logic sleepEnable,
    input wire logic forceMode,
    input wire logic forceSleep,
    input wire tsb_pkg::tsb_rep_t repMode,
    input wire logic idleHoldOne,
    input wire logic [NCH-1:0] mapA,
    input wire logic [NCH-1:0] mapB,
    input wire logic [NCH*`TSB_DUTY_W-1:0] chanDuty,
    input wire logic [`TSB_DUTY_W-1:0] idleDutyA,
    input wire logic [`TSB_DUTY_W-1:0] idleDutyB,
    input wire logic buzzEnable,
    input wire logic buzzIdleLevel,
    input wire logic [1:0] buzzTone1,
    input wire logic [1:0] buzzTone2,
    input wire logic [4:0] buzzLen1,
    input wire logic [4:0] buzzLen2,
    output logic senseStart,
    output logic [3:0] senseSlot,
    output logic [NCH-1:0] senseCombine,
    output logic ledDrive,
    output logic sleepMode,
    output logic [NCH-1:0] buttonStatus,
    output logic proxStatus,
    output logic [NCH-1:0] reportStatus,
    output logic statusIrq,
    output logic levelOutputA,
    output logic levelOutputB,
    output logic buzzerOut
);
    import tsb_pkg::*;

    function automatic logic [3:0] lowIdx(input logic [NCH-1:0] v);
        logic [3:0] r;
        r = 4'hF;
        for (int i = NCH - 1; i >= 0; i--)
            if (v[i])
                r = 4'(i);
        return r;
    endfunction

    // slot sequencer: each slot = sensing half then LED half
    logic [15:0] slotCnt_reg;
    logic [3:0] slot_reg;
    logic ledHalf_reg;
    logic [SKIP_W-1:0] skipCnt_reg;
    logic frameAny_reg;
    logic [DW-1:0] strength_reg [NCH];
    wire halfEnd = (slotCnt_reg == 16'(SLOT_CYC - 1));
    wire slotEnd = halfEnd && ledHalf_reg;
    wire frameEnd = slotEnd && (slot_reg == `TSB_LAST_SLOT);
    wire inSkip = (skipCnt_reg != '0);
    wire [SKIP_W-1:0] skipLoad = sleepMode ? sleepSkip : activeSkip;
    wire slotIsProx = (slot_reg == `TSB_PROX_SLOT);
    wire slotEn = slotIsProx ? proxEnable : chanEnable[slot_reg[2:0]];
    wire measure = !inSkip && slotEn;
    wire [3:0] nextSlot = (slot_reg == `TSB_LAST_SLOT) ? 4'h0 : slot_reg + 4'h1;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            slotCnt_reg <= 16'h0000;
            slot_reg <= 4'h0;
            ledHalf_reg <= 1'b0;
            skipCnt_reg <= '0;
            senseStart <= 1'b0;
            senseSlot <= 4'h0;
            senseCombine <= '0;
            ledDrive <= 1'b0;
        end
        else
        begin
            slotCnt_reg <= halfEnd ? 16'h0000 : slotCnt_reg + 16'h0001;
            if (halfEnd)
                ledHalf_reg <= !ledHalf_reg;
            if (slotEnd)
                slot_reg <= nextSlot;
            // skip frames follow each measured frame, period = frame + skips
            if (frameEnd)
                skipCnt_reg <= inSkip ? skipCnt_reg - 1'b1 : skipLoad;
            senseStart <= (slotCnt_reg == 16'h0000) && !ledHalf_reg && measure;
            senseSlot <= slot_reg;
            senseCombine <= (slotIsProx && measure) ? proxCombineMask : '0;
            ledDrive <= ledHalf_reg;
        end
    end

    // touch detection with hysteresis
    wire [DW:0] onLvl = {1'b0, threshold} + {1'b0, hysteresis};
    wire [DW:0] offLvl = {1'b0, threshold} - {1'b0, hysteresis};
    wire offNeg = (hysteresis > threshold);
    wire valIsOn = ({1'b0, senseValue} >= onLvl);
    wire valIsOff = !offNeg && ({1'b0, senseValue} < offLvl);
    wire capture = senseDone && ledHalf_reg == 1'b0 && !inSkip;
    logic [NCH-1:0] btnNext;
    logic proxNext;
    always_comb
    begin
        btnNext = buttonStatus;
        proxNext = proxStatus;
        if (capture && slotIsProx)
            proxNext = valIsOn ? 1'b1 : (valIsOff ? 1'b0 : proxStatus);
        else if (capture)
        begin
            if (valIsOn)
                btnNext[slot_reg[2:0]] = 1'b1;
            else if (valIsOff)
                btnNext[slot_reg[2:0]] = 1'b0;
        end
        btnNext = btnNext & chanEnable;
    end
    wire stateChange = (btnNext != buttonStatus) || (proxNext != proxStatus);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            buttonStatus <= '0;
            proxStatus <= 1'b0;
            statusIrq <= 1'b0;
            frameAny_reg <= 1'b0;
            sleepMode <= 1'b0;
            for (int i = 0; i < NCH; i++)
                strength_reg[i] <= '0;
        end
        else
        begin
            buttonStatus <= btnNext;
            proxStatus <= proxNext;
            statusIrq <= stateChange;
            if (capture && !slotIsProx)
                strength_reg[slot_reg[2:0]] <= senseValue;
            frameAny_reg <= frameEnd ? 1'b0 : (frameAny_reg || (|btnNext) || proxNext);
            if (forceMode)
                sleepMode <= forceSleep;
            else if (sleepMode && ((|btnNext) || proxNext))
                sleepMode <= 1'b0;
            else if (frameEnd && !inSkip && sleepEnable && !frameAny_reg)
                sleepMode <= 1'b1;
        end
    end

    // reporting: one index held; 4'hF means none
    logic [3:0] rep_reg;
    logic idleGap_reg;
    wire [NCH-1:0] newTouch = btnNext & ~buttonStatus;
    wire repHeld = (rep_reg != 4'hF) && btnNext[rep_reg[2:0]];
    logic [3:0] strongIdx;
    always_comb
    begin
        strongIdx = rep_reg;
        for (int i = 0; i < NCH; i++)
            if (btnNext[i] && (strongIdx == 4'hF || !btnNext[strongIdx[2:0]] ||
                strength_reg[i] > strength_reg[strongIdx[2:0]]))
                strongIdx = 4'(i);
    end
    wire [3:0] repNext =
        (repMode == TSB_REP_SINGLE) ? (repHeld ? rep_reg : lowIdx(btnNext)) :
        (repMode == TSB_REP_STRONG) ? strongIdx : 4'hF;
    wire repSwitch = (rep_reg != 4'hF) && (repNext != rep_reg) && (repNext != 4'hF);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            rep_reg <= 4'hF;
            idleGap_reg <= 1'b0;
            reportStatus <= '0;
        end
        else
        begin
            rep_reg <= repNext;
            // optional idle level between reports, held until the end of the current measured frame
            if (repSwitch && idleHoldOne)
                idleGap_reg <= 1'b1;
            else if (frameEnd && !inSkip)
                idleGap_reg <= 1'b0;
            reportStatus <= (repMode == TSB_REP_ALL) ? btnNext :
                ((repNext == 4'hF) ? '0 : (NCH'(1) << repNext[2:0]));
        end
    end

    wire showRep = (rep_reg != 4'hF) && !idleGap_reg && (repMode != TSB_REP_ALL);
    wire [`TSB_DUTY_W-1:0] repDuty = chanDuty[rep_reg[2:0]*`TSB_DUTY_W +: `TSB_DUTY_W];
    wire [`TSB_DUTY_W-1:0] dutyA = (showRep && mapA[rep_reg[2:0]]) ? repDuty : idleDutyA;
    wire [`TSB_DUTY_W-1:0] dutyB = (showRep && mapB[rep_reg[2:0]]) ? repDuty : idleDutyB;

    tsb_pwm u_pwmA (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .duty(dutyA),
        .pwmOut(levelOutputA)
    );
    tsb_pwm u_pwmB (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .duty(dutyB),
        .pwmOut(levelOutputB)
    );

    // buzzer: triggered by new touches only, so holds never retrigger
    tsb_bz_t bz_reg;
    logic [19:0] bzTime_reg;
    logic [15:0] bzHalf_reg;
    wire [4:0] lenSel = (bz_reg == TSB_BZ_PH1) ? buzzLen1 : buzzLen2;
    wire [4:0] lenMs = (lenSel < 5'(`TSB_PHASE_MS_MIN)) ? 5'(`TSB_PHASE_MS_MIN) :
        ((lenSel > 5'(`TSB_PHASE_MS_MAX)) ? 5'(`TSB_PHASE_MS_MAX) : lenSel);
    wire [1:0] toneSel = (bz_reg == TSB_BZ_PH1) ? buzzTone1 : buzzTone2;
    wire [15:0] halfCyc = 16'(`TSB_HALF_1K) >> toneSel;
    wire phaseEnd = (bzTime_reg == 20'(lenMs * `TSB_CYC_PER_MS - 1));
    wire halfEnd2 = (bzHalf_reg >= halfCyc - 16'h0001);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            bz_reg <= TSB_BZ_IDLE;
            bzTime_reg <= 20'h00000;
            bzHalf_reg <= 16'h0000;
            buzzerOut <= 1'b0;
        end
        else
        begin
            unique case (bz_reg)
                TSB_BZ_IDLE:
                begin
                    buzzerOut <= buzzIdleLevel;
                    bzTime_reg <= 20'h00000;
                    bzHalf_reg <= 16'h0000;
                    if (buzzEnable && (|newTouch))
                        bz_reg <= TSB_BZ_PH1;
                end
                TSB_BZ_PH1, TSB_BZ_PH2:
                begin
                    bzTime_reg <= phaseEnd ? 20'h00000 : bzTime_reg + 20'h00001;
                    bzHalf_reg <= (halfEnd2 || phaseEnd) ? 16'h0000 : bzHalf_reg + 16'h0001;
                    if (halfEnd2)
                        buzzerOut <= !buzzerOut;
                    if (phaseEnd)
                        bz_reg <= (bz_reg == TSB_BZ_PH1) ? TSB_BZ_PH2 : TSB_BZ_IDLE;
                end
                default:
                    bz_reg <= TSB_BZ_IDLE;
            endcase
        end
    end

    a_frame_wrap: assert property (@(posedge clk_sys) disable iff (!rst_b)
        frameEnd |=> slot_reg == 4'h0)
        else $error("frame did not wrap after slot eight");
    a_slot_order: assert property (@(posedge clk_sys) disable iff (!rst_b)
        slotEnd && slot_reg != `TSB_LAST_SLOT |=> slot_reg == $past(slot_reg) + 4'h1)
        else $error("slot skipped");
    a_skip_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b)
        inSkip |=> !senseStart)
        else $error("measurement in skip frame");
    a_force_mode: assert property (@(posedge clk_sys) disable iff (!rst_b)
        forceMode |=> sleepMode == $past(forceSleep))
        else $error("forced mode not held");
    a_wake_touch: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !forceMode && sleepMode && (|btnNext) |=> !sleepMode)
        else $error("touch did not wake");
    a_touch_hyst: assert property (@(posedge clk_sys) disable iff (!rst_b)
        capture && !slotIsProx && valIsOn && chanEnable[slot_reg[2:0]]
        |=> buttonStatus[$past(slot_reg[2:0])])
        else $error("touch above threshold missed");
    a_irq_change: assert property (@(posedge clk_sys) disable iff (!rst_b)
        stateChange |=> statusIrq)
        else $error("no irq on change");
    a_buzz_once: assert property (@(posedge clk_sys) disable iff (!rst_b)
        bz_reg == TSB_BZ_IDLE && !(buzzEnable && (|newTouch)) |=> bz_reg == TSB_BZ_IDLE)
        else $error("buzzer started without new touch");
    a_all_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
        repMode == TSB_REP_ALL |=> rep_reg == 4'hF)
        else $error("level output reported in all mode");
endmodule

// >>> verif/tsb_afe_model.sv
`timescale 1ns/1ps
module tsb_afe_model #(
    parameter int DW = 12
) (
    input wire logic clk_sys,
    input wire logic senseStart,
    input wire logic [3:0] senseSlot,
    input wire logic [7:0] senseCombine,
    input wire logic [8*DW-1:0] chanVal,
    input wire logic slow,
    output logic [DW-1:0] senseValue,
    output logic senseDone
);
    logic [3:0] slot;
    logic [7:0] comb;
    // parallel sensors add up; saturate like a full-scale reading
    function automatic logic [DW-1:0] combSum(input logic [7:0] m);
        int acc;
        acc = 0;
        for (int i = 0; i < 8; i++)
            if (m[i])
                acc += int'(chanVal[i*DW +: DW]);
        return (acc > (2 ** DW - 1)) ? '1 : DW'(acc);
    endfunction
    initial
    begin
        senseDone = 1'b0;
        senseValue = '0;
    end
    // answer one or two cycles after the start pulse, inside the sensing half
    always @(posedge clk_sys)
    begin
        if (senseStart === 1'b1)
        begin
            slot = senseSlot;
            comb = senseCombine;
            repeat (slow ? 2 : 1) @(posedge clk_sys);
            // combined slot reads the channels put in parallel
            senseValue <= (slot == 4'h8) ? combSum(comb) : chanVal[slot*DW +: DW];
            senseDone <= 1'b1;
            @(posedge clk_sys);
            senseDone <= 1'b0;
            // stale data must not look valid after the pulse
            senseValue <= ~senseValue;
        end
    end
endmodule

// >>> verif/touch_scan_and_button_reporting_tb.sv
`timescale 1ns/1ps
module touch_scan_and_button_reporting_tb;
    import tsb_pkg::*;
    // five cycles per half so a slow front-end answer still lands in the sensing half
    localparam int SC = 5;
    localparam int FR = 18 * SC;
    localparam int PER = 640;
    typedef struct {string nm; logic [31:0] exp;} tsb_note_t;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] chanEnable = 8'hFF;
    // only the last channel feeds the combined slot; earlier tests never touch it
    logic [7:0] proxCombineMask = 8'h80;
    logic [7:0] mapA = 8'hFF;
    logic [7:0] mapB = 8'h00;
    logic proxEnable = 1'b1;
    logic sleepEnable = 1'b0;
    logic forceMode = 1'b0;
    logic forceSleep = 1'b0;
    logic idleHoldOne = 1'b0;
    logic buzzEnable = 1'b1;
    logic buzzIdleLevel = 1'b0;
    logic [1:0] buzzTone1 = 2'h0;
    logic [1:0] buzzTone2 = 2'h0;
    logic [4:0] buzzLen1 = 5'h05;
    logic [4:0] buzzLen2 = 5'h05;
    logic [11:0] threshold = 12'h100;
    logic [11:0] hysteresis = 12'h010;
    logic [3:0] activeSkip = 4'h0;
    logic [3:0] sleepSkip = 4'h1;
    tsb_rep_t repMode = TSB_REP_ALL;
    // duty ch1 6'h20, ch2 6'h10, ch5 6'h30
    logic [47:0] chanDuty = 48'h000C_0001_0800;
    logic [5:0] idleDutyA = 6'h04;
    logic [5:0] idleDutyB = 6'h08;
    logic [95:0] chanVal = '0;
    logic slow = 1'b0;
    logic [11:0] senseValue;
    logic senseDone, senseStart, ledDrive, sleepMode, proxStatus, statusIrq;
    logic [3:0] senseSlot;
    logic [7:0] senseCombine, buttonStatus, reportStatus;
    logic levelOutputA, levelOutputB, buzzerOut;
    tsb_note_t expQ[$];
    logic [31:0] seen;
    event shown;
    int errCount = 0;
    int nTests = 0;
    int irqCount = 0;
    int buzzRise = 0;
    logic buzzPrev = 1'b0;

    tsb_touch_scan #(.SLOT_CYC(SC)) DUT (
        .clk_sys, .rst_b, .chanEnable, .proxEnable, .proxCombineMask, .senseValue,
        .senseDone, .threshold, .hysteresis, .activeSkip, .sleepSkip, .sleepEnable,
        .forceMode, .forceSleep, .repMode, .idleHoldOne, .mapA, .mapB, .chanDuty,
        .idleDutyA, .idleDutyB, .buzzEnable, .buzzIdleLevel, .buzzTone1, .buzzTone2,
        .buzzLen1, .buzzLen2, .senseStart, .senseSlot, .senseCombine, .ledDrive,
        .sleepMode, .buttonStatus, .proxStatus, .reportStatus, .statusIrq,
        .levelOutputA, .levelOutputB, .buzzerOut
    );
    tsb_afe_model AFE (
        .clk_sys, .senseStart, .senseSlot, .senseCombine, .chanVal, .slow, .senseValue,
        .senseDone
    );

    always #25 clk_sys = ~clk_sys;

    always @(negedge clk_sys)
    begin
        if (statusIrq === 1'b1)
            irqCount++;
        if (buzzerOut === 1'b1 && buzzPrev !== 1'b1)
            buzzRise++;
        buzzPrev = buzzerOut;
    end

    task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
        nTests++;
        if (got !== exp)
        begin
            errCount++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, got);
        end
    endtask

    always @(shown)
    begin
        tsb_note_t n;
        n = expQ.pop_front();
        check(n.nm, seen, n.exp);
    end

    task automatic cmp(string nm, logic [31:0] got, logic [31:0] exp);
        expQ.push_back('{nm, exp});
        seen = got;
        ->shown;
        // checker takes the note in this time step, stimulus stays on the falling edge
        #0;
    endtask

    task automatic endOfTest();
        $display("checks %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic settle(int n);
        repeat (n * FR) @(negedge clk_sys);
    endtask

    task automatic setVal(int ch, int v);
        chanVal[ch*12 +: 12] = 12'(v);
    endtask

    task automatic nextStart(output int c, output int leds);
        logic lp;
        c = 0;
        leds = 0;
        lp = ledDrive;
        do
        begin
            @(negedge clk_sys);
            c++;
            if (ledDrive === 1'b1 && lp !== 1'b1)
                leds++;
            lp = ledDrive;
        end
        while (senseStart !== 1'b1 && c < 5000);
        if (c >= 5000)
        begin
            errCount++;
            endOfTest();
        end
    endtask

    task automatic gapSlot0(output int c, output int leds);
        int a, b;
        c = 0;
        leds = 0;
        do
        begin
            nextStart(a, b);
            c += a;
            leds += b;
        end
        while (senseSlot !== 4'h0 && c < 20000);
        if (c >= 20000)
        begin
            errCount++;
            endOfTest();
        end
    endtask

    // one full duty period after the latch point
    task automatic pwm(output int a, output int b);
        a = 0;
        b = 0;
        repeat (PER) @(negedge clk_sys);
        repeat (PER)
        begin
            @(negedge clk_sys);
            if (levelOutputA === 1'b1)
                a++;
            if (levelOutputB === 1'b1)
                b++;
        end
    endtask

    initial
    begin
        int c, l, a, b, t, i, s;
        s = $urandom(32'h15AE1AED);
        repeat (4) @(negedge clk_sys);
        rst_b = 1'b1;
        cmp("buzzerOut", buzzerOut, buzzIdleLevel);
        nextStart(c, l);
        for (i = 0; i < 10; i++)
        begin
            t = (senseSlot == 4'h8) ? 0 : senseSlot + 1;
            nextStart(c, l);
            cmp("senseSlot", senseSlot, t);
            cmp("slotGap", c, 2 * SC);
            if (senseSlot == 4'h8)
                cmp("senseCombine", senseCombine, proxCombineMask);
        end
        $display("test order done");
        chanEnable = 8'h0B;
        proxEnable = 1'b0;
        activeSkip = 4'h2;
        gapSlot0(c, l);
        gapSlot0(c, l);
        cmp("scanPeriod", c, 3 * FR);
        cmp("ledPulses", l, 27);
        chanEnable = 8'hFF;
        proxEnable = 1'b1;
        activeSkip = 4'h0;
        $display("test skip done");
        slow = 1'b1;
        threshold = 12'(200 + $urandom % 1000);
        hysteresis = 12'(1 + $urandom % 50);
        setVal(3, threshold + hysteresis - 1);
        settle(2);
        cmp("buttonStatus", buttonStatus, 0);
        t = irqCount;
        b = buzzRise;
        setVal(3, threshold + hysteresis);
        settle(2);
        cmp("buttonStatus", buttonStatus, 8'h08);
        cmp("irqPulses", irqCount - t, 1);
        for (i = 0; i < 20100 && buzzRise == b; i++)
            @(negedge clk_sys);
        cmp("buzzStarted", buzzRise > b, 1);
        setVal(3, threshold - hysteresis);
        settle(2);
        cmp("buttonStatus", buttonStatus, 8'h08);
        setVal(3, threshold - hysteresis - 1);
        settle(2);
        cmp("buttonStatus", buttonStatus, 0);
        slow = 1'b0;
        $display("test hysteresis done");
        sleepEnable = 1'b1;
        settle(3);
        cmp("sleepMode", sleepMode, 1);
        gapSlot0(c, l);
        gapSlot0(c, l);
        cmp("sleepPeriod", c, 2 * FR);
        setVal(1, 12'hFFF);
        settle(4);
        cmp("sleepMode", sleepMode, 0);
        forceMode = 1'b1;
        forceSleep = 1'b1;
        settle(2);
        cmp("sleepMode", sleepMode, 1);
        forceSleep = 1'b0;
        settle(2);
        cmp("sleepMode", sleepMode, 0);
        forceMode = 1'b0;
        sleepEnable = 1'b0;
        setVal(1, 0);
        settle(2);
        $display("test sleep done");
        repMode = TSB_REP_SINGLE;
        setVal(2, 12'hE00);
        setVal(5, 12'hFFF);
        settle(2);
        cmp("reportStatus", reportStatus, 8'h04);
        pwm(a, b);
        cmp("levelA", a, 160);
        cmp("levelB", b, 80);
        setVal(2, 0);
        settle(2);
        cmp("reportStatus", reportStatus, 8'h20);
        pwm(a, b);
        cmp("levelA", a, 480);
        setVal(5, 0);
        settle(2);
        repMode = TSB_REP_STRONG;
        setVal(1, 12'hE00);
        settle(2);
        setVal(6, 12'hFFF);
        settle(2);
        cmp("reportStatus", reportStatus, 8'h40);
        setVal(1, 0);
        settle(2);
        cmp("reportStatus", reportStatus, 8'h40);
        repMode = TSB_REP_ALL;
        setVal(1, 12'hE00);
        settle(2);
        cmp("buttonStatus", buttonStatus, 8'h42);
        pwm(a, b);
        cmp("levelA", a, 40);
        setVal(7, 12'hFFF);
        settle(2);
        cmp("proxStatus", proxStatus, 1);
        $display("test report done");
        endOfTest();
    end
endmodule
